// >>> sim/exec_partner.sv
// Far-side model: register file and a simplified shifter operand unit.
// Assumes write ports from the execute unit arrive one cycle after issue.
module exec_partner
    import exec_pkg::*;
(
    input wire logic clk_in,
    input wire logic [31:0] instr_in,
    input wire reg_write_t dest_wr_in,
    input wire reg_write_t link_wr_in,
    output logic [31:0] first_operand_out,
    output logic [31:0] imm_operand_out,
    output logic imm_carry_out,
    output logic [31:0] reg_operand_out,
    output logic reg_carry_out
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [31:0] regs [16];

    initial begin
        for (int i = 0; i < 16; i++) begin
            regs[i] = 32'h0;
        end
        regs[1] = 32'h7fff_ffff;
        regs[2] = 32'h0000_0001;
        regs[3] = 32'hffff_ffff;
        regs[4] = 32'hf0f0_f0f0;
    end

    always @(posedge clk_in) begin
        if (dest_wr_in.valid) begin
            regs[dest_wr_in.index] <= dest_wr_in.data;
        end
        if (link_wr_in.valid) begin
            regs[link_wr_in.index] <= link_wr_in.data;
        end
    end

    // Both operand forms offered at once so a wrong pick shows
    assign first_operand_out = regs[instr_in[19:16]];
    assign imm_operand_out = {24'h0, instr_in[7:0]};
    assign imm_carry_out = instr_in[11];
    assign reg_operand_out = regs[instr_in[3:0]];
    assign reg_carry_out = instr_in[4];
endmodule

// >>> sim/exec_unit_tb.sv
// Self-checking bench for the execute unit with the operand model.
// Assumes a 100 MHz clock and one-cycle answers on every output.
module exec_unit_tb;
    import exec_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;

    typedef struct packed {
        logic [31:0] word;
        logic wr;
        logic [31:0] data;
        logic [3:0] nzcv;
        logic skip;
    } row_t;

    logic clk, rst, instr_valid, imm_carry, reg_carry, wr, rd;
    logic [31:0] instr, instr_addr, first_op, imm_op, reg_op, saved, wdata;
    logic [31:0] rdata, pc_value, status;
    logic [3:0] addr;
    reg_write_t dest_wr, link_wr;
    logic pc_load, unpred, skipped;
    int bad_count, cmp_count;

    // Rows run in order; each sees the flags left by the previous one
    row_t rows [9] = '{
        '{32'he091_5002, 1'b1, 32'h8000_0000, 4'h9, 1'b0},
        '{32'he293_6001, 1'b1, 32'h0000_0000, 4'h6, 1'b0},
        '{32'he2b1_7000, 1'b1, 32'h8000_0000, 4'h9, 1'b0},
        '{32'he0a2_8002, 1'b1, 32'h0000_0002, 4'h9, 1'b0},
        '{32'he214_98f0, 1'b1, 32'h0000_00f0, 4'h3, 1'b0},
        '{32'he1d4_a004, 1'b1, 32'h0000_0000, 4'h5, 1'b0},
        '{32'h1091_b002, 1'b0, 32'h0000_0000, 4'h5, 1'b1},
        '{32'hf091_b002, 1'b0, 32'h0000_0000, 4'h5, 1'b1},
        '{32'he031_b002, 1'b0, 32'h0000_0000, 4'h5, 1'b1}
    };

    exec_unit DUT (
        .clk_in(clk), .sys_rst_in(rst), .instr_valid_in(instr_valid),
        .instr_in(instr), .instr_addr_in(instr_addr),
        .first_operand_in(first_op), .imm_operand_in(imm_op),
        .imm_carry_in(imm_carry), .reg_operand_in(reg_op),
        .reg_carry_in(reg_carry), .saved_status_word_in(saved),
        .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_wr_in(wr),
        .reg_rd_in(rd), .reg_rdata_out(rdata), .dest_wr_out(dest_wr),
        .link_wr_out(link_wr), .pc_load_out(pc_load),
        .pc_value_out(pc_value), .current_status_word_out(status),
        .unpredictable_out(unpred), .skipped_out(skipped)
    );

    exec_partner pm (
        .clk_in(clk), .instr_in(instr), .dest_wr_in(dest_wr),
        .link_wr_in(link_wr), .first_operand_out(first_op),
        .imm_operand_out(imm_op), .imm_carry_out(imm_carry),
        .reg_operand_out(reg_op), .reg_carry_out(reg_carry)
    );

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic check_val(input string name, input logic [31:0] exp,
                             input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            bad_count++;
            $display("unexpected %s: expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic wrap_up;
        $display("compares %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // One-cycle issue; outputs are looked at in the answering cycle
    task automatic run_instr(input logic [31:0] word, input logic [31:0] a);
        @(posedge clk);
        instr_valid <= 1'b1;
        instr <= word;
        instr_addr <= a;
        @(posedge clk);
        instr_valid <= 1'b0;
        #1;
    endtask

    task automatic reg_write(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    task automatic reg_read(input logic [3:0] a, input logic [31:0] exp);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        check_val("read data", exp, rdata);
    endtask

    initial begin
        repeat (5000) @(posedge clk);
        bad_count++;
        wrap_up();
    end

    initial begin
        rst = 1'b1;
        {instr_valid, wr, rd, addr} = '0;
        {instr, instr_addr, saved, wdata} = '0;
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        #1;
        check_val("reset status", STATUS_RESET, status);
        check_val("reset dest", 32'h0, {31'h0, dest_wr.valid});
        // --------------------------------------------------------------
        // Table of data operations
        // --------------------------------------------------------------
        foreach (rows[i]) begin
            run_instr(rows[i].word, 32'h0000_0100);
            check_val("dest valid", {31'h0, rows[i].wr},
                      {31'h0, dest_wr.valid});
            check_val("dest data", rows[i].data,
                      rows[i].wr ? dest_wr.data : 32'h0);
            check_val("dest index", {28'h0, rows[i].word[15:12]},
                      {28'h0, rows[i].wr ? dest_wr.index
                                         : rows[i].word[15:12]});
            check_val("flags", {28'h0, rows[i].nzcv},
                      {28'h0, status[31:28]});
            check_val("skipped", {31'h0, rows[i].skip},
                      {31'h0, skipped});
        end
        // --------------------------------------------------------------
        // Branches; targets stay inside the address space
        // --------------------------------------------------------------
        run_instr(32'hebff_fffe, 32'h0000_1000);
        check_val("pc load", 32'h1, {31'h0, pc_load});
        check_val("pc value", 32'h0000_1000, pc_value);
        check_val("link valid", 32'h1, {31'h0, link_wr.valid});
        check_val("link index", {28'h0, RETURN_INDEX},
                  {28'h0, link_wr.index});
        check_val("link data", 32'h0000_1004, link_wr.data);
        run_instr(32'hea00_0010, 32'h0000_2000);
        check_val("pc value", 32'h0000_2048, pc_value);
        check_val("link valid", 32'h0, {31'h0, link_wr.valid});
        // --------------------------------------------------------------
        // Counter as destination, register port, status restore
        // --------------------------------------------------------------
        run_instr(32'he282_f004, 32'h0000_0100);
        check_val("pc load", 32'h1, {31'h0, pc_load});
        check_val("pc value", 32'h0000_0005, pc_value);
        check_val("dest valid", 32'h0, {31'h0, dest_wr.valid});
        check_val("status", 32'h5000_0013, status);
        reg_read(ADDR_RESULT, 32'h0000_0005);
        reg_read(4'h8, 32'h0);
        reg_write(ADDR_RESULT, 32'h0000_dead);
        reg_read(ADDR_RESULT, 32'h0000_0005);
        reg_write(ADDR_STATUS, 32'h2000_0010);
        reg_read(ADDR_STATUS, 32'h2000_0010);
        run_instr(32'he2a2_b000, 32'h0000_0100);
        check_val("carry add", 32'h0000_0002, dest_wr.data);
        @(posedge clk);
        saved <= 32'h9000_0013;
        run_instr(32'he292_f004, 32'h0000_0100);
        check_val("pc value", 32'h0000_0005, pc_value);
        check_val("restored", 32'h9000_0013, status);
        check_val("user restore", 32'h1, {31'h0, unpred});
        run_instr(32'he292_f004, 32'h0000_0100);
        check_val("super restore", 32'h0, {31'h0, unpred});
        wrap_up();
    end
endmodule

// >>> src/cond_check.sv
// Condition field evaluation against the N, Z, C, V flags.
// Combinational; flags come from the current status word.
module cond_check
    import exec_pkg::*;
(
    input wire logic [3:0] cond_in,
    input wire logic [3:0] nzcv_in,
    output logic pass_out
);

    logic n;
    logic z;
    logic c;
    logic v;
    logic base;

    always_comb begin
        {n, z, c, v} = nzcv_in;
        unique case (cond_in[3:1])
            3'h0: base = z;
            3'h1: base = c;
            3'h2: base = n;
            3'h3: base = v;
            3'h4: base = c && !z;
            3'h5: base = (n == v);
            3'h6: base = !z && (n == v);
            3'h7: base = 1'b1;
        endcase
        // Odd codes invert, except code 4'hf, which never passes
        if (cond_in == 4'hf) begin
            pass_out = 1'b0;
        end else begin
            pass_out = cond_in[0] ? !base : base;
        end
    end

endmodule

// >>> src/exec_pkg.sv
// Shared constants and types for the add, logic and branch execute unit.
// Assumes one 100 MHz clock and an asynchronous active-high reset.
package exec_pkg;

    // ------------------------------------------------------------------
    // Instruction fields
    // ------------------------------------------------------------------
    localparam int COND_MSB = 31;
    localparam int COND_LSB = 28;
    localparam int CLASS_MSB = 27;
    localparam int CLASS_LSB = 25;
    localparam int IMM_FORM_BIT = 25;
    localparam int LINK_BIT = 24;
    localparam int OPC_MSB = 24;
    localparam int OPC_LSB = 21;
    localparam int FLAG_UPD_BIT = 20;
    localparam int FIRST_REG_LSB = 16;
    localparam int RD_LSB = 12;
    localparam int OFFSET_MSB = 23;

    localparam logic [1:0] CLASS_DATA_HI = 2'h0;
    localparam logic [2:0] CLASS_BRANCH = 3'h5;
    localparam logic [3:0] OPC_AND = 4'h0;
    localparam logic [3:0] OPC_ADD = 4'h4;
    localparam logic [3:0] OPC_ADC = 4'h5;
    localparam logic [3:0] OPC_CLEAR_BITS = 4'he;

    // ------------------------------------------------------------------
    // Registers, status word layout and figures
    // ------------------------------------------------------------------
    localparam int FLAG_N = 31;
    localparam int FLAG_Z = 30;
    localparam int FLAG_C = 29;
    localparam int FLAG_V = 28;
    localparam logic [4:0] MODE_USER = 5'h10;
    localparam logic [4:0] MODE_SYSTEM = 5'h1f;
    localparam logic [3:0] PC_INDEX = 4'hf;
    localparam logic [3:0] RETURN_INDEX = 4'he;
    localparam logic [31:0] PC_AHEAD = 32'h0000_0008;
    localparam logic [31:0] NEXT_INSTR = 32'h0000_0004;
    localparam logic [31:0] STATUS_RESET = 32'h0000_0013;
    localparam logic [3:0] ADDR_STATUS = 4'h0;
    localparam logic [3:0] ADDR_RESULT = 4'h4;

    typedef enum logic [2:0] {
        OP_NONE = 3'b000,
        OP_AND = 3'b001,
        OP_CLEAR = 3'b010,
        OP_ADD = 3'b011,
        OP_ADC = 3'b100,
        OP_BRANCH = 3'b101
    } op_kind_t;

    typedef struct packed {
        logic valid;
        logic [3:0] index;
        logic [31:0] data;
    } reg_write_t;

endpackage

// >>> src/exec_unit.sv
// Execute stage for add, add with carry, AND, bit clear and branch.
// Assumes operands arrive with the instruction in the same cycle and
// that the register file takes the write ports in the cycle after.
//
// Functional notes
// RQ1 - Add with carry writes first operand plus shifter operand plus carry.
// RQ2 - Add with carry sets overflow from the signed three-term sum.
// RQ3 - Both additions update N, Z, C, V only when flag bit is set.
// RQ4 - Bit 25 picks immediate or register shifter operand form.
// RQ5 - Destination 15 without flag bit loads the counter, flags untouched.
// RQ6 - Destination 15 with flag bit loads counter and restores saved status.
// RQ7 - Source never issues flag form to counter in user or system mode.
// RQ8 - Nothing executes unless the condition field passes.
// RQ9 - Plain add writes first operand plus shifter operand, no carry.
// RQ10 - AND writes conjunction; N from bit 31, Z when result zero.
// RQ11 - Logical ops take carry from shifter, leave overflow unchanged.
// RQ12 - Bit clear writes first operand AND inverted shifter operand.
// RQ13 - Branch target adds sign-extended offset shifted left two places.
// RQ14 - Counter value added equals branch address plus eight.
// RQ15 - Link form writes following address into register 14.
// RQ16 - Software never branches past either end of the address space.
module exec_unit
    import exec_pkg::*;
(
    input wire logic clk_in,
    input wire logic sys_rst_in,
    input wire logic instr_valid_in,
    input wire logic [31:0] instr_in,
    input wire logic [31:0] instr_addr_in,
    input wire logic [31:0] first_operand_in,
    input wire logic [31:0] imm_operand_in,
    input wire logic imm_carry_in,
    input wire logic [31:0] reg_operand_in,
    input wire logic reg_carry_in,
    input wire logic [31:0] saved_status_word_in,
    input wire logic [3:0] reg_addr_in,
    input wire logic [31:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    output logic [31:0] reg_rdata_out,
    output reg_write_t dest_wr_out,
    output reg_write_t link_wr_out,
    output logic pc_load_out,
    output logic [31:0] pc_value_out,
    output logic [31:0] current_status_word_out,
    output logic unpredictable_out,
    output logic skipped_out
);

    // ------------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------------
    logic [31:0] current_status_word_reg;
    logic [31:0] current_status_word_next;
    logic [31:0] last_result_reg;
    logic [3:0] nzcv;
    logic cond_pass;
    logic exec;
    logic flag_upd;
    logic [3:0] rd_idx;
    logic to_pc;
    op_kind_t op_kind;

    assign nzcv = current_status_word_reg[FLAG_N:FLAG_V];
    assign flag_upd = instr_in[FLAG_UPD_BIT];
    assign rd_idx = instr_in[RD_LSB +: 4];
    assign to_pc = (rd_idx == PC_INDEX);

    cond_check u_cond (
        .cond_in(instr_in[COND_MSB:COND_LSB]),
        .nzcv_in(nzcv),
        .pass_out(cond_pass)
    );

    always_comb begin
        op_kind = OP_NONE;
        if (instr_in[CLASS_MSB:CLASS_LSB] == CLASS_BRANCH) begin
            op_kind = OP_BRANCH;
        end else if (instr_in[CLASS_MSB:CLASS_LSB + 1] == CLASS_DATA_HI) begin
            unique case (instr_in[OPC_MSB:OPC_LSB])
                OPC_AND: op_kind = OP_AND;
                OPC_CLEAR_BITS: op_kind = OP_CLEAR;
                OPC_ADD: op_kind = OP_ADD;
                OPC_ADC: op_kind = OP_ADC;
                default: op_kind = OP_NONE;
            endcase
        end
    end

    assign exec = instr_valid_in && cond_pass && (op_kind != OP_NONE); // RQ8

    // ------------------------------------------------------------------
    // Operand select and arithmetic
    // ------------------------------------------------------------------
    logic [31:0] shifter_op;
    logic shifter_carry;
    logic add_carry_in;
    logic [31:0] add_sum;
    logic add_carry;
    logic add_ovf;
    logic [31:0] result;
    logic [31:0] branch_offset;
    logic [31:0] branch_target;
    logic [31:0] pc_ahead;
    logic [31:0] link_addr;

    always_comb begin
        if (instr_in[IMM_FORM_BIT]) begin // RQ4
            shifter_op = imm_operand_in;
            shifter_carry = imm_carry_in;
        end else begin
            shifter_op = reg_operand_in;
            shifter_carry = reg_carry_in;
        end
    end

    // Carry enters the sum only for add with carry
    assign add_carry_in = (op_kind == OP_ADC)
                          && current_status_word_reg[FLAG_C]; // RQ1 RQ9

    sum_unit u_sum (
        .a_in(first_operand_in),
        .b_in(shifter_op),
        .carry_in(add_carry_in),
        .sum_out(add_sum),
        .carry_out(add_carry),
        .overflow_out(add_ovf)
    );

    always_comb begin
        unique case (op_kind)
            OP_AND: result = first_operand_in & shifter_op; // RQ10
            OP_CLEAR: result = first_operand_in & ~shifter_op; // RQ12
            OP_ADD, OP_ADC: result = add_sum; // RQ1 RQ9
            default: result = 32'h0000_0000;
        endcase
    end

    assign pc_ahead = instr_addr_in + PC_AHEAD; // RQ14
    assign branch_offset = {{6{instr_in[OFFSET_MSB]}},
                            instr_in[OFFSET_MSB:0], 2'b00}; // RQ13
    assign branch_target = pc_ahead + branch_offset; // RQ13
    assign link_addr = instr_addr_in + NEXT_INSTR; // RQ15

    // ------------------------------------------------------------------
    // Status word
    // ------------------------------------------------------------------
    logic is_arith;
    logic is_logic;
    logic restore;
    logic flag_write;

    assign is_arith = (op_kind == OP_ADD) || (op_kind == OP_ADC);
    assign is_logic = (op_kind == OP_AND) || (op_kind == OP_CLEAR);
    assign restore = exec && !(op_kind == OP_BRANCH) && flag_upd && to_pc;
    assign flag_write = exec && (is_arith || is_logic) && flag_upd
                        && !to_pc;

    always_comb begin
        current_status_word_next = current_status_word_reg;
        if (restore) begin
            current_status_word_next = saved_status_word_in; // RQ6
        end else if (flag_write) begin // RQ3
            current_status_word_next[FLAG_N] = result[31]; // RQ10
            current_status_word_next[FLAG_Z] = (result == 32'h0000_0000);
            if (is_arith) begin
                current_status_word_next[FLAG_C] = add_carry; // RQ3
                current_status_word_next[FLAG_V] = add_ovf; // RQ2
            end else begin
                current_status_word_next[FLAG_C] = shifter_carry; // RQ11
            end
        end else if (reg_wr_in && reg_addr_in == ADDR_STATUS) begin
            // Software write loses to an executing flag update
            current_status_word_next = reg_wdata_in;
        end
    end

    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            current_status_word_reg <= STATUS_RESET;
        end else begin
            current_status_word_reg <= current_status_word_next;
        end
    end

    assign current_status_word_out = current_status_word_reg;

    // ------------------------------------------------------------------
    // Result ports
    // ------------------------------------------------------------------
    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            dest_wr_out <= '0;
            link_wr_out <= '0;
            pc_load_out <= 1'b0;
            pc_value_out <= 32'h0000_0000;
            skipped_out <= 1'b0;
        end else begin
            dest_wr_out.valid <= exec && (is_arith || is_logic) && !to_pc;
            dest_wr_out.index <= rd_idx;
            dest_wr_out.data <= result;
            // Return address and redirect leave together
            link_wr_out.valid <= exec && (op_kind == OP_BRANCH)
                                 && instr_in[LINK_BIT]; // RQ15
            link_wr_out.index <= RETURN_INDEX; // RQ15
            link_wr_out.data <= link_addr;
            if (exec && op_kind == OP_BRANCH) begin
                pc_load_out <= 1'b1;
                pc_value_out <= branch_target; // RQ13
            end else if (exec && to_pc) begin
                pc_load_out <= 1'b1; // RQ5 RQ6
                pc_value_out <= result;
            end else begin
                pc_load_out <= 1'b0;
            end
            skipped_out <= instr_valid_in && !exec; // RQ8
        end
    end

    // Flags the issuing side breaking the restore restriction
    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            unpredictable_out <= 1'b0;
        end else begin
            unpredictable_out <= restore &&
                ((current_status_word_reg[4:0] == MODE_USER) ||
                 (current_status_word_reg[4:0] == MODE_SYSTEM)); // RQ7
        end
    end

    // ------------------------------------------------------------------
    // Register port
    // ------------------------------------------------------------------
    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            last_result_reg <= 32'h0000_0000;
        end else if (exec && op_kind != OP_BRANCH) begin
            last_result_reg <= result;
        end
    end

    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            reg_rdata_out <= 32'h0000_0000;
        end else if (reg_rd_in) begin
            unique case (reg_addr_in)
                ADDR_STATUS: reg_rdata_out <= current_status_word_reg;
                ADDR_RESULT: reg_rdata_out <= last_result_reg;
                default: reg_rdata_out <= 32'h0000_0000;
            endcase
        end else begin
            reg_rdata_out <= 32'h0000_0000;
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    // Reference sums built apart from the adder, zero- and sign-extended
    logic ref_carry;
    logic [32:0] carry_sum_ref;
    logic [32:0] signed_sum_ref;

    assign ref_carry = (op_kind == OP_ADC) && nzcv[1];
    assign carry_sum_ref = {1'b0, first_operand_in} + {1'b0, shifter_op} +
        {32'h0000_0000, ref_carry};
    assign signed_sum_ref = {first_operand_in[31], first_operand_in} +
        {shifter_op[31], shifter_op} +
        {32'h0000_0000, ref_carry};

    add_with_carry_a: assert property ( // RQ1
        @(posedge clk_in) disable iff (sys_rst_in)
        (exec && op_kind == OP_ADC && !to_pc) |=> (dest_wr_out.valid &&
            dest_wr_out.data == $past(first_operand_in) +
            $past(shifter_op) + {31'h0, $past(nzcv[1])}))
        else $error("add with carry result wrong");

    carry_overflow_a: assert property ( // RQ2
        @(posedge clk_in) disable iff (sys_rst_in)
        (flag_write && op_kind == OP_ADC) |=>
            current_status_word_reg[FLAG_V] ==
            $past(signed_sum_ref[32] ^ signed_sum_ref[31]))
        else $error("add with carry overflow wrong");

    arith_carry_a: assert property ( // RQ3
        @(posedge clk_in) disable iff (sys_rst_in)
        (flag_write && is_arith) |=> (current_status_word_reg[FLAG_C] ==
            $past(carry_sum_ref[32]) && dest_wr_out.data ==
            $past(carry_sum_ref[31:0])))
        else $error("add carry flag wrong");

    flags_hold_a: assert property ( // RQ3
        @(posedge clk_in) disable iff (sys_rst_in)
        (instr_valid_in && is_arith && !flag_upd && !reg_wr_in) |=>
            $stable(current_status_word_reg[FLAG_N:FLAG_V]))
        else $error("flags changed without update bit");

    operand_form_a: assert property ( // RQ4
        @(posedge clk_in) disable iff (sys_rst_in)
        (exec && op_kind == OP_AND && !to_pc && instr_in[IMM_FORM_BIT]) |=>
            dest_wr_out.data == ($past(first_operand_in) &
            $past(imm_operand_in)))
        else $error("immediate form not used");

    pc_plain_load_a: assert property ( // RQ5
        @(posedge clk_in) disable iff (sys_rst_in)
        (exec && op_kind != OP_BRANCH && to_pc && !flag_upd && !reg_wr_in)
        |=> (pc_load_out && pc_value_out == $past(result) &&
            !dest_wr_out.valid && $stable(current_status_word_reg)))
        else $error("counter load disturbed flags");

    status_restore_a: assert property ( // RQ6
        @(posedge clk_in) disable iff (sys_rst_in)
        restore |=> (pc_load_out && current_status_word_reg ==
            $past(saved_status_word_in)))
        else $error("status not restored with counter");

    cond_gate_a: assert property ( // RQ8
        @(posedge clk_in) disable iff (sys_rst_in)
        (instr_valid_in && !cond_pass) |=> (!dest_wr_out.valid &&
            !pc_load_out && !link_wr_out.valid && skipped_out))
        else $error("failed condition still executed");

    plain_add_a: assert property ( // RQ9
        @(posedge clk_in) disable iff (sys_rst_in)
        (exec && op_kind == OP_ADD && !to_pc) |=> dest_wr_out.data ==
            $past(first_operand_in) + $past(shifter_op))
        else $error("plain add result wrong");

    logic_zero_a: assert property ( // RQ10
        @(posedge clk_in) disable iff (sys_rst_in)
        (flag_write && is_logic) |=> (current_status_word_reg[FLAG_Z] ==
            (dest_wr_out.data == 32'h0000_0000) &&
            current_status_word_reg[FLAG_N] == dest_wr_out.data[31]))
        else $error("logic N or Z flag wrong");

    logic_carry_a: assert property ( // RQ11
        @(posedge clk_in) disable iff (sys_rst_in)
        (flag_write && is_logic) |=> (current_status_word_reg[FLAG_C] ==
            $past(shifter_carry) && $stable(current_status_word_reg[FLAG_V])))
        else $error("logic carry or overflow wrong");

    clear_bits_a: assert property ( // RQ12
        @(posedge clk_in) disable iff (sys_rst_in)
        (exec && op_kind == OP_CLEAR && !to_pc) |=> dest_wr_out.data ==
            ($past(first_operand_in) & ~$past(shifter_op)))
        else $error("bit clear result wrong");

    branch_target_a: assert property ( // RQ13 RQ14
        @(posedge clk_in) disable iff (sys_rst_in)
        (exec && op_kind == OP_BRANCH) |=> (pc_load_out && pc_value_out ==
            $past(instr_addr_in) + 32'h0000_0008 +
            {{6{$past(instr_in[23])}}, $past(instr_in[23:0]), 2'b00}))
        else $error("branch target wrong");

    link_write_a: assert property ( // RQ15
        @(posedge clk_in) disable iff (sys_rst_in)
        (exec && op_kind == OP_BRANCH && instr_in[LINK_BIT]) |=>
            (link_wr_out.valid && link_wr_out.index == 4'he &&
            link_wr_out.data == $past(instr_addr_in) + 32'h0000_0004))
        else $error("return address not written");

endmodule

// >>> src/sum_unit.sv
// Three-term 32-bit adder with carry and signed overflow outputs.
// Purely combinational; the caller registers the results.
module sum_unit
    import exec_pkg::*;
(
    input wire logic [31:0] a_in,
    input wire logic [31:0] b_in,
    input wire logic carry_in,
    output logic [31:0] sum_out,
    output logic carry_out,
    output logic overflow_out
);

    logic [32:0] wide;

    always_comb begin
        wide = {1'b0, a_in} + {1'b0, b_in} + {32'h0000_0000, carry_in};
        sum_out = wide[31:0];
        carry_out = wide[32];
        // Same operand signs giving a result of the other sign
        overflow_out = (a_in[31] == b_in[31]) && (wide[31] != a_in[31]);
    end

endmodule
